// ### verilog/stc_pkg.sv
// Shared constants, types and register layout for the stepper control registers
package stc_pkg;

  // Register addresses, as carried in the low five bits of the command byte
  localparam logic [4:0] ADDR_STEP_AMP  = 5'h01;
  localparam logic [4:0] ADDR_DRIVE_CFG = 5'h02;
  localparam logic [4:0] ADDR_MOTOR_PWR = 5'h03;

  // Reset values
  localparam logic [7:0] RST_STEP_AMP  = 8'h00;
  localparam logic [7:0] RST_DRIVE_CFG = 8'h00;
  localparam logic [7:0] RST_MOTOR_PWR = 8'h00;

  // Field positions in step_amplitude_ctrl
  localparam int STEP_MODE_LSB  = 5;
  localparam int COIL_PEAK_LSB  = 0;
  // Field positions in drive_config_ctrl
  localparam int DIR_INV_BIT    = 7;
  localparam int EDGE_SEL_BIT   = 6;
  localparam int CHOP_DBL_BIT   = 5;
  localparam int DITHER_BIT     = 4;
  localparam int SLOPE_LSB      = 0;
  // Field positions in motor_power_ctrl
  localparam int BRIDGE_EN_BIT  = 7;
  localparam int LOW_POWER_BIT  = 6;
  localparam int ANGLE_GAIN_BIT = 5;
  localparam int ANGLE_HOLD_BIT = 4;

  // Serial frame layout: command byte first, MSB first
  localparam logic [4:0] FRAME_WRITE_BITS = 5'h10;
  localparam logic [4:0] FRAME_COUNT_MAX  = 5'h1F;
  localparam int         FRAME_CMD_BIT    = 15;
  localparam int         FRAME_ADDR_LSB   = 8;
  localparam int         FRAME_DATA_LSB   = 0;

  // Timing: system clock and base chop frequency
  localparam int CLK_HZ          = 100_000_000;
  localparam int PWM_BASE_HZ     = 22_800;
  localparam int PWM_BASE_CYCLES = CLK_HZ / PWM_BASE_HZ;
  localparam int PWM_CNT_W       = 13;

  // Angle output gain as right shifts (0.5 and 0.25)
  localparam int ANGLE_SHIFT_HALF    = 1;
  localparam int ANGLE_SHIFT_QUARTER = 2;

  // Step resolution codes
  typedef enum logic [2:0] {
    STC_MODE_32TH      = 3'h0,
    STC_MODE_16TH      = 3'h1,
    STC_MODE_8TH       = 3'h2,
    STC_MODE_4TH       = 3'h3,
    STC_MODE_HALF_UNC  = 3'h4,
    STC_MODE_HALF_COMP = 3'h5,
    STC_MODE_FULL      = 3'h6,
    STC_MODE_RESERVED  = 3'h7
  } stc_step_mode_e;

  // Frame captured on the link clock, read after deselect
  typedef struct packed {
    logic [4:0]  bit_count;
    logic [15:0] word;
  } stc_frame_s;

endpackage : stc_pkg

// ### verilog/stc_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module stc_sync #(
  parameter int                WIDTH     = 1,
  parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // Both stages reset to the idle level of the pins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : stc_sync

// ### verilog/stc_spi_link.sv
// Serial link shifter on the link clock: frame capture and read-back data
`timescale 1ns/1ps
module stc_spi_link (
  input  wire logic             spi_clk,
  input  wire logic             chip_select_n,
  input  wire logic             spi_din,
  input  wire logic [7:0]       step_amp,
  input  wire logic [7:0]       drive_cfg,
  input  wire logic [7:0]       motor_pwr,
  output stc_pkg::stc_frame_s   frame,
  output logic                  spi_dout_o,
  output logic                  spi_dout_oe
);

  logic       new_frame;   // Set while deselected, cleared by first edge
  logic [2:0] bit_in_byte; // Bits taken in the current byte, wraps at 8
  logic [7:0] shift_out;   // Data going out, MSB first
  logic [7:0] read_value;  // Register selected by the last byte received
  logic [4:0] rd_addr;     // Address field of the last byte received

  // The link clock stops between frames, so the frame start is marked
  // by an asynchronous preset from the deselected chip select
  always_ff @(posedge spi_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
      new_frame <= 1'b1;
    else
      new_frame <= 1'b0;
  end

  // Sample input data and count bits on the rising edge
  always_ff @(posedge spi_clk)
  begin
    frame.word <= {frame.word[14:0], spi_din};
    if (new_frame)
    begin
      frame.bit_count <= 5'h01;
      bit_in_byte     <= 3'h1;
    end
    else
    begin
      // Saturating count: anything past the cap is simply too long
      if (frame.bit_count != stc_pkg::FRAME_COUNT_MAX)
        frame.bit_count <= frame.bit_count + 5'h01;
      bit_in_byte <= bit_in_byte + 3'h1;
    end
  end

  // Read-back select; registers only change while deselected, so they are
  // stable for the whole frame and need no resynchronising here
  assign rd_addr = frame.word[4:0];
  assign read_value = (rd_addr == stc_pkg::ADDR_STEP_AMP)  ? step_amp  :
                      (rd_addr == stc_pkg::ADDR_DRIVE_CFG) ? drive_cfg :
                      (rd_addr == stc_pkg::ADDR_MOTOR_PWR) ? motor_pwr : 8'h00;

  // Shift out on the falling edge; reload after every eighth bit
  always_ff @(negedge spi_clk or posedge chip_select_n)
  begin
    if (chip_select_n)
      shift_out <= 8'hFF;
    else if (!new_frame && bit_in_byte == 3'h0)
      shift_out <= read_value;
    else
      shift_out <= {shift_out[6:0], 1'b1};
  end

  // Open-drain output: pull low only for a zero bit while selected
  assign spi_dout_o  = 1'b0;
  assign spi_dout_oe = ~chip_select_n & ~shift_out[7];

endmodule : stc_spi_link

// ### verilog/stc_control_regs.sv
// Stepper control register bank with serial access and decoded controls
`timescale 1ns/1ps
module stc_control_regs #(
  parameter logic [12:0] PWM_BASE_CYCLES = 13'(stc_pkg::PWM_BASE_CYCLES)
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        spi_clk,
  input  wire logic        chip_select_n,
  input  wire logic        spi_din,
  output logic             spi_dout_o,
  output logic             spi_dout_oe,
  input  wire logic        dir_pin,
  input  wire logic        step_advance_pin,
  input  wire logic [7:0]  speed_angle_src,
  output logic [7:0]       speed_angle_output,
  output logic             step_pulse,
  output logic             motor_ccw,
  output logic [5:0]       step_increment,
  output logic             half_compensated,
  output logic             step_mode_reserved,
  output logic [4:0]       coil_peak_level,
  output logic [1:0]       slope_rate_sel,
  output logic             chop_dither_en,
  output logic             chop_sync,
  output logic             bridge_enable,
  output logic             low_power
);

  // Stored control registers
  logic [7:0] step_amplitude_ctrl;
  logic [7:0] drive_config_ctrl;
  logic [7:0] motor_power_ctrl;

  // Frame from the link domain
  stc_pkg::stc_frame_s frame;

  // Synchronised pins: chip select, direction, step
  logic [2:0] pins_s;
  logic       csb_s;
  logic       dir_s;
  logic       step_s;
  logic       csb_prev;   // Chip select one cycle back
  logic       step_prev;  // Step pin one cycle back

  // Decoded frame fields
  logic       commit_evt;
  logic       frame_is_write;
  logic       write_ok;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_amp;
  logic       wr_cfg;
  logic       wr_pwr;

  // Named control fields
  stc_pkg::stc_step_mode_e step_mode;
  logic       dir_invert;
  logic       edge_falling;
  logic       chop_double;
  logic       angle_gain_quarter;
  logic       angle_hold;

  // Step edge detect
  logic       step_rise;
  logic       step_fall;
  logic       next_step_pulse;

  // Chop timing
  logic [12:0] pwm_count;
  logic [12:0] period_sel;
  logic [12:0] period_jit;
  logic        pwm_wrap;
  logic [7:0]  lfsr;

  // Angle output scaling
  logic [7:0]  next_angle;

  // Link-side shifter
  stc_spi_link u_link (
    .spi_clk       (spi_clk),
    .chip_select_n (chip_select_n),
    .spi_din       (spi_din),
    .step_amp      (step_amplitude_ctrl),
    .drive_cfg     (drive_config_ctrl),
    .motor_pwr     (motor_power_ctrl),
    .frame         (frame),
    .spi_dout_o    (spi_dout_o),
    .spi_dout_oe   (spi_dout_oe)
  );

  // Pin synchroniser; chip select idles high
  stc_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_pin_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({chip_select_n, dir_pin, step_advance_pin}),
    .sync_out (pins_s)
  );

  assign csb_s  = pins_s[2];
  assign dir_s  = pins_s[1];
  assign step_s = pins_s[0];

  // Edge history of synchronised pins
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      csb_prev  <= 1'b1;
      step_prev <= 1'b0;
    end
    else
    begin
      csb_prev  <= csb_s;
      step_prev <= step_s;
    end
  end

  // Deselect edge; the link clock has stopped by now, so the frame
  // captured on it is stable and safe to read here
  assign commit_evt     = csb_s & ~csb_prev;
  assign frame_is_write = frame.word[stc_pkg::FRAME_CMD_BIT];
  assign write_ok = commit_evt & frame_is_write & (frame.bit_count == stc_pkg::FRAME_WRITE_BITS);
  assign wr_addr  = frame.word[stc_pkg::FRAME_ADDR_LSB +: 5];
  assign wr_data  = frame.word[stc_pkg::FRAME_DATA_LSB +: 8];
  // Writes to other addresses (watchdog, status) do nothing here
  assign wr_amp   = write_ok & (wr_addr == stc_pkg::ADDR_STEP_AMP);
  assign wr_cfg   = write_ok & (wr_addr == stc_pkg::ADDR_DRIVE_CFG);
  assign wr_pwr   = write_ok & (wr_addr == stc_pkg::ADDR_MOTOR_PWR);

  // Register storage; all bits kept, unused ones included
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      step_amplitude_ctrl <= stc_pkg::RST_STEP_AMP;
      drive_config_ctrl   <= stc_pkg::RST_DRIVE_CFG;
      motor_power_ctrl    <= stc_pkg::RST_MOTOR_PWR;
    end
    else
    begin
      if (wr_amp)
        step_amplitude_ctrl <= wr_data;
      if (wr_cfg)
        drive_config_ctrl <= wr_data;
      if (wr_pwr)
        motor_power_ctrl <= wr_data;
    end
  end

  assign step_mode       = stc_pkg::stc_step_mode_e'(step_amplitude_ctrl[stc_pkg::STEP_MODE_LSB +: 3]);
  assign coil_peak_level = step_amplitude_ctrl[stc_pkg::COIL_PEAK_LSB +: 5];
  assign dir_invert      = drive_config_ctrl[stc_pkg::DIR_INV_BIT];
  assign edge_falling    = drive_config_ctrl[stc_pkg::EDGE_SEL_BIT];
  assign chop_double     = drive_config_ctrl[stc_pkg::CHOP_DBL_BIT];
  assign chop_dither_en  = drive_config_ctrl[stc_pkg::DITHER_BIT];
  assign slope_rate_sel  = drive_config_ctrl[stc_pkg::SLOPE_LSB +: 2];
  assign low_power          = motor_power_ctrl[stc_pkg::LOW_POWER_BIT];
  assign angle_gain_quarter = motor_power_ctrl[stc_pkg::ANGLE_GAIN_BIT];
  assign angle_hold         = motor_power_ctrl[stc_pkg::ANGLE_HOLD_BIT];

  always_comb
  begin
    half_compensated   = 1'b0;
    step_mode_reserved = 1'b0;
    unique case (step_mode)
      stc_pkg::STC_MODE_32TH:      step_increment = 6'h01;
      stc_pkg::STC_MODE_16TH:      step_increment = 6'h02;
      stc_pkg::STC_MODE_8TH:       step_increment = 6'h04;
      stc_pkg::STC_MODE_4TH:       step_increment = 6'h08;
      stc_pkg::STC_MODE_HALF_UNC:  step_increment = 6'h10;
      stc_pkg::STC_MODE_HALF_COMP:
      begin
        step_increment   = 6'h10;
        half_compensated = 1'b1;
      end
      stc_pkg::STC_MODE_FULL:      step_increment = 6'h20;
      stc_pkg::STC_MODE_RESERVED:
      begin
        // Reserved code: no movement rather than a guess
        step_increment     = 6'h00;
        step_mode_reserved = 1'b1;
      end
    endcase
  end

  // Step pin edges after synchronisation
  assign step_rise = step_s & ~step_prev;
  assign step_fall = ~step_s & step_prev;
  assign next_step_pulse = edge_falling ? step_fall : step_rise;

  // Registered step, direction and bridge outputs
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      step_pulse    <= 1'b0;
      motor_ccw     <= 1'b0;
      bridge_enable <= 1'b0;
    end
    else
    begin
      step_pulse    <= next_step_pulse;
      motor_ccw     <= dir_s ^ dir_invert;
      bridge_enable <= motor_power_ctrl[stc_pkg::BRIDGE_EN_BIT];
    end
  end

  assign period_sel = chop_double ? (PWM_BASE_CYCLES >> 1) : PWM_BASE_CYCLES;
  // Dither stretches each period by up to 15 cycles to spread emissions
  assign period_jit = chop_dither_en ? (period_sel + {9'h000, lfsr[3:0]}) : period_sel;
  assign pwm_wrap   = (pwm_count >= period_jit - 13'h0001);

  // Chop counter and dither source; counter cleared, dither source held in low power to save toggling
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pwm_count <= 13'h0000;
      chop_sync <= 1'b0;
      lfsr      <= 8'h01;
    end
    else if (low_power)
    begin
      pwm_count <= 13'h0000;
      chop_sync <= 1'b0;
    end
    else
    begin
      chop_sync <= pwm_wrap;
      pwm_count <= pwm_wrap ? 13'h0000 : pwm_count + 13'h0001;
      if (pwm_wrap)
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  assign next_angle = angle_gain_quarter ? (speed_angle_src >> stc_pkg::ANGLE_SHIFT_QUARTER)
                                         : (speed_angle_src >> stc_pkg::ANGLE_SHIFT_HALF);

  // Angle output: tracks while transparent, freezes while held
  always_ff @(posedge clk)
  begin
    if (srst)
      speed_angle_output <= 8'h00;
    else if (!angle_hold)
      speed_angle_output <= next_angle;
  end

  // Checks on the system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Own disable term: the default one would switch this check off whenever reset is high
  reset_zero_a: assert property (disable iff (1'b0) srst |=>
    step_amplitude_ctrl == 8'h00 && drive_config_ctrl == 8'h00 && motor_power_ctrl == 8'h00)
    else $error("control register not zero after reset");

  amp_write_a: assert property (wr_amp |=>
    step_mode == $past(wr_data[7:5]) && coil_peak_level == $past(wr_data[4:0]))
    else $error("step amplitude write lost");

  cfg_write_a: assert property (wr_cfg |=>
    dir_invert == $past(wr_data[7]) && chop_dither_en == $past(wr_data[4]) && slope_rate_sel == $past(wr_data[1:0]))
    else $error("drive config write lost");

  pwr_write_a: assert property (wr_pwr |=>
    motor_power_ctrl == $past(wr_data) ##1 bridge_enable == $past(wr_data[7], 2))
    else $error("motor power write lost");

  angle_hold_a: assert property (angle_hold && $past(angle_hold) |=>
    $stable(speed_angle_output))
    else $error("held angle output moved");

  angle_gain_a: assert property (!angle_hold |=>
    speed_angle_output == ($past(angle_gain_quarter) ? $past(speed_angle_src) >> 2 : $past(speed_angle_src) >> 1))
    else $error("angle gain wrong");

  chop_rate_a: assert property (!chop_dither_en |->
    period_jit == (chop_double ? (PWM_BASE_CYCLES / 13'h0002) : PWM_BASE_CYCLES))
    else $error("chop period wrong");

  bridge_out_a: assert property ($rose(motor_power_ctrl[7]) |->
    !bridge_enable ##1 bridge_enable)
    else $error("bridge enable late");

  dir_sense_a: assert property (dir_s == dir_invert && $stable(dir_s) && $stable(dir_invert) |=>
    !motor_ccw)
    else $error("direction sense wrong");

  step_edge_a: assert property (step_rise && !edge_falling |=> step_pulse ##1 !step_pulse)
    else $error("step edge missed");

  full_mode_a: assert property (step_mode == stc_pkg::STC_MODE_FULL |-> step_increment == 6'h20)
    else $error("full step decode wrong");

  bad_len_a: assert property (commit_evt && frame.bit_count != 5'h10 |=>
    $stable(step_amplitude_ctrl) && $stable(drive_config_ctrl) && $stable(motor_power_ctrl))
    else $error("bad length frame committed");

  write_cov: cover property (write_ok);
  reject_cov: cover property (commit_evt && frame_is_write && !write_ok);
  step_cov: cover property (step_pulse && edge_falling);
  chop_cov: cover property (chop_sync && chop_double);

endmodule : stc_control_regs

// ### tb/stc_spi_master.sv
// Behavioural mode 0 link master that drives the control register port
`timescale 1ns/1ps
module stc_spi_master (
  output logic      spi_clk,
  output logic      chip_select_n,
  output logic      spi_din,
  input  wire logic spi_dout_o,
  input  wire logic spi_dout_oe
);
  // Open-drain data line with its pull-up
  wire do_line = spi_dout_oe ? spi_dout_o : 1'b1;

  // Idle: clock low and stopped, deselected
  initial
  begin
    spi_clk       = 1'b0;
    chip_select_n = 1'b1;
    spi_din       = 1'b1;
  end

  // Shift n bits of tx out MSB first and collect the data line into rx
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    #37.3 chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      spi_din = tx[i];
      #80 spi_clk = 1'b1;
      rx = {rx[30:0], do_line};
      #80 spi_clk = 1'b0;
    end
    #37.3 chip_select_n = 1'b1;
    // Released data shows the inverse, so a stale bit is never read as valid
    spi_din = ~spi_din;
    // Deselect gap is long enough for the commit into the clk domain
    #100;
  endtask : xfer
endmodule : stc_spi_master

// ### tb/tb.sv
// Self-checking bench for the stepper control register bank
`timescale 1ns/1ps
module tb;
  logic       clk;                 // System clock
  logic       srst;                // Synchronous reset
  logic       spi_clk;             // Link clock, runs only inside frames
  logic       chip_select_n;       // Link select
  logic       spi_din;             // Master data
  logic       spi_dout_o;          // Device data value
  logic       spi_dout_oe;         // Device pulls data low
  logic       dir_pin;             // Direction pin
  logic       step_advance_pin;    // Step pin
  logic [7:0] speed_angle_src;     // Angle source
  logic [7:0] speed_angle_output;  // Scaled angle
  logic       step_pulse;          // Step strobe
  logic       motor_ccw;           // Rotation sense
  logic [5:0] step_increment;      // Microsteps per step
  logic       half_compensated;    // Compensated half step
  logic       step_mode_reserved;  // Reserved code seen
  logic [4:0] coil_peak_level;     // Peak level field
  logic [1:0] slope_rate_sel;      // Slope field
  logic       chop_dither_en;      // Jitter enable
  logic       chop_sync;           // Chop period strobe
  logic       bridge_enable;       // Bridge outputs on
  logic       low_power;           // Sleep request
  int         err_count;           // Mismatches
  int         compares;            // Comparisons made
  int         k;                   // Result of the measuring tasks
  int         acc;                 // Sum of several chop periods
  logic [7:0] rdat;                // Last read data
  logic [5:0] incr_tbl [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h10, 6'h20, 6'h00};

  // Free running system clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Small chop period keeps the run short
  stc_control_regs #(.PWM_BASE_CYCLES(13'h0028)) stc_control_regs_inst (
    .clk, .srst, .spi_clk, .chip_select_n, .spi_din, .spi_dout_o, .spi_dout_oe,
    .dir_pin, .step_advance_pin, .speed_angle_src, .speed_angle_output, .step_pulse,
    .motor_ccw, .step_increment, .half_compensated, .step_mode_reserved, .coil_peak_level,
    .slope_rate_sel, .chop_dither_en, .chop_sync, .bridge_enable, .low_power);

  stc_spi_master stc_spi_master_inst (
    .spi_clk, .chip_select_n, .spi_din, .spi_dout_o, .spi_dout_oe);

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Wait n cycles, landing just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One 16-bit write frame
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    stc_spi_master_inst.xfer(16, {16'h0000, 8'h80 | a, d}, r);
  endtask : wr

  // One 16-bit read frame; the first byte out is the released line
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [31:0] r;
    stc_spi_master_inst.xfer(16, {16'h0000, a, 8'h00}, r);
    chk(r[15:8], 8'hFF);
    d = r[7:0];
  endtask : rd

  // Count step strobes over n cycles
  task automatic cnt_steps(input int n);
    k = 0;
    repeat (n)
    begin
      tick(1);
      if (step_pulse === 1'b1) k++;
    end
  endtask : cnt_steps

  // Cycles between two chop strobes, bounded
  task automatic chop_period();
    k = 0;
    while (chop_sync !== 1'b1 && k < 300)
    begin
      tick(1);
      k++;
    end
    k = 0;
    do
    begin
      tick(1);
      k++;
    end while (chop_sync !== 1'b1 && k < 300);
  endtask : chop_period

  // Counts, then one verdict and the end of the run
  task automatic give_verdict();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Watchdog against a hung handshake
  initial
  begin
    #500000;
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end

  // Main sequence
  initial
  begin
    srst = 1'b1;
    dir_pin = 1'b0;
    step_advance_pin = 1'b0;
    speed_angle_src = 8'hC8;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    #1 srst = 1'b0;
    tick(3);
    // Registers and decoded outputs after reset
    for (int a = 1; a <= 3; a++)
    begin
      rd(8'(a), rdat);
      chk(rdat, 8'h00);
    end
    chk({2'h0, bridge_enable, low_power, chop_dither_en, slope_rate_sel, motor_ccw}, 8'h00);
    chk({3'h0, coil_peak_level}, 8'h00);
    // Field placement and read-back of all three registers
    wr(8'h01, 8'hB7);
    chk({3'h0, coil_peak_level}, 8'h17);
    chk({7'h0, half_compensated}, 8'h01);
    rd(8'h01, rdat);
    chk(rdat, 8'hB7);
    wr(8'h02, 8'hB5);
    chk({5'h0, chop_dither_en, slope_rate_sel}, 8'h05);
    rd(8'h02, rdat);
    chk(rdat, 8'hB5);
    wr(8'h03, 8'hCF);
    chk({6'h0, bridge_enable, low_power}, 8'h03);
    rd(8'h03, rdat);
    chk(rdat, 8'hCF);
    // Sleep holds the chop strobe off
    cnt_steps(1);
    k = 0;
    repeat (100)
    begin
      tick(1);
      if (chop_sync === 1'b1) k++;
    end
    chk(8'(k), 8'h00);
    // Last bit one, so a short frame would look like a write to 01h if counted wrong
    wr(8'h03, 8'h01);
    chk({7'h0, bridge_enable}, 8'h00);
    // Short and long frames are discarded whole; both would write 01h otherwise
    stc_spi_master_inst.xfer(15, 32'h0000_0155, k);
    stc_spi_master_inst.xfer(17, 32'h0000_8178, k);
    rd(8'h01, rdat);
    chk(rdat, 8'hB7);
    // Every step mode code
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h01, {3'(m), 5'h00});
      chk({2'h0, step_increment}, {2'h0, incr_tbl[m]});
      chk({7'h0, step_mode_reserved}, {7'h0, m == 7});
    end
    // Direction pin against the invert bit
    for (int v = 0; v < 4; v++)
    begin
      wr(8'h02, {v[1], 7'h00});
      @(posedge clk);
      #1 dir_pin = v[0];
      tick(6);
      chk({7'h0, motor_ccw}, {7'h0, v[1] ^ v[0]});
    end
    // Step edge selection: rising then falling
    for (int e = 0; e < 2; e++)
    begin
      wr(8'h02, {1'b0, e[0], 6'h00});
      @(posedge clk);
      #1 step_advance_pin = 1'b1;
      cnt_steps(10);
      chk(8'(k), {7'h0, e == 0});
      step_advance_pin = 1'b0;
      cnt_steps(10);
      chk(8'(k), {7'h0, e == 1});
    end
    // Chop period at base and doubled rate
    wr(8'h02, 8'h00);
    chop_period();
    chk(8'(k), 8'h28);
    wr(8'h02, 8'h20);
    chop_period();
    chk(8'(k), 8'h14);
    // Jitter stretches each period by 0 to 15 cycles, never four times by zero
    wr(8'h02, 8'h10);
    acc = 0;
    repeat (4)
    begin
      chop_period();
      acc += k;
    end
    chk(8'(acc > 160 && acc <= 220), 8'h01);
    // Angle gain, transparency and hold
    wr(8'h03, 8'h00);
    chk(speed_angle_output, 8'h64);
    wr(8'h03, 8'h20);
    chk(speed_angle_output, 8'h32);
    wr(8'h03, 8'h30);
    @(posedge clk);
    #1 speed_angle_src = 8'h50;
    tick(6);
    chk(speed_angle_output, 8'h32);
    wr(8'h03, 8'h20);
    chk(speed_angle_output, 8'h14);
    // Hard reset in mid-run clears every register again
    @(posedge clk);
    #1 srst = 1'b1;
    tick(2);
    srst = 1'b0;
    tick(3);
    for (int a = 1; a <= 3; a++)
    begin
      rd(8'(a), rdat);
      chk(rdat, 8'h00);
    end
    give_verdict();
  end
endmodule : tb
